// File: fwos_defs.svh
// Register offsets, field positions, reset values and timing counts of the flash sequencer
`ifndef FWOS_DEFS_SVH
`define FWOS_DEFS_SVH
`define FWOS_OFF_CTRL0_LOW 8'h00
`define FWOS_OFF_CTRL0_HIGH 8'h04
`define FWOS_OFF_SEC_LOW 8'h08
`define FWOS_OFF_SEC_HIGH 8'h0C
`define FWOS_OFF_ADDR_LOW 8'h10
`define FWOS_OFF_ADDR_HIGH 8'h14
`define FWOS_OFF_WD0_LOW 8'h18
`define FWOS_OFF_WD0_HIGH 8'h1C
`define FWOS_OFF_WD1_LOW 8'h20
`define FWOS_OFF_WD1_HIGH 8'h24
`define FWOS_OFF_ERROR 8'h28
`define FWOS_OFF_TEMP_UNPROT 8'h2C
`define FWOS_OFF_NV_WP 8'h30
`define FWOS_OFF_NV_AP0 8'h34
`define FWOS_OFF_NV_DIS 8'h38
`define FWOS_OFF_NV_REEN 8'h3C
`define FWOS_BIT_START 15
`define FWOS_BIT_SUSPEND_BIT 14
`define FWOS_BIT_WPG 13
`define FWOS_BIT_DWORD_PROG_SEL 12
`define FWOS_BIT_SER 11
`define FWOS_BIT_SPR 8
`define FWOS_BIT_BUSY 4
`define FWOS_BIT_RESERR 0
`define FWOS_BIT_ACCESS_PROTECT_BIT 0
`define FWOS_BIT_ADDR2 2
`define FWOS_SEL_MASK 16'h3900
`define FWOS_NV_ADDR_HIGH 16'h0008
`define FWOS_NV_WP_LOW 16'hDFB4
`define FWOS_NV_AP0_LOW 16'hDFB8
`define FWOS_NV_AP1_LOW 16'hDFBC
`define FWOS_RST_NV 16'hFFFF
`define FWOS_RST_ZERO 16'h0000
`define FWOS_PROG_NS 2000
`define FWOS_ERASE_NS 40000
`define FWOS_CLK_NS 40
`define FWOS_PROG_CYC ((`FWOS_PROG_NS + `FWOS_CLK_NS - 1) / `FWOS_CLK_NS)
`define FWOS_ERASE_CYC ((`FWOS_ERASE_NS + `FWOS_CLK_NS - 1) / `FWOS_CLK_NS)
`endif

// File: fwos_pkg.sv
// Types shared by the flash sequencer
package fwos_pkg;
   typedef enum logic [2:0] {
      FWOS_IDLE,
      FWOS_PROG,
      FWOS_ERASE,
      FWOS_PROG_IN_SUSPEND_BIT,
      FWOS_SUSPENDED
   } fwos_state_e;
   typedef struct packed {
      logic wr;
      logic [15:0] data;
      logic [23:0] addr;
      logic [63:0] wdata;
      logic [1:0] kind;
   } fwos_array_cmd_s;
endpackage

// File: fwos_seq.sv
// Flash write-operation sequencer with AXI4-Lite register access
//
// What this block does
// - Register writes must come register-indirect; device accepts only such writes.
// - Only 16-bit wide writes are taken; other strobes are refused.
// - Select one operation, load operands, then set start bit 0x8000.
// - Control high half: suspend, word, double-word, erase, set-protect select bits.
// - Word program writes 32-bit data register 0 to the address pair.
// - Double-word program writes 64 bits at even-word address, address bit 2 ignored.
// - Sector erase erases every sector set in sector select halves.
// - Clearing a select bit before start cancels, array untouched.
// - Setting suspend during program or erase suspends it.
// - Sector select halves read zero once erase has completed.
// - Resume with different select bits aborts and sets resume error, unless a word or double-word program is selected.
// - Program during erase suspend cannot be suspended; erase and suspend read low.
// - Suspended erase resumes by setting erase select then start.
// - Set-protection targets protection registers at fixed addresses, high 0x0008.
// - Writing 0xFFF0 to write-protect register protects four lowest sectors; here the value is only stored, erase and program do not check it.
// - Writing 0xFFFC to access-protect register 0 enables access and debug protection; only access protection from bit 0 is built here.
// - Re-enable: set temp unprotect, set-protect 0xFFFE to enable reg, clear it.
// - Permanent disable and re-enable possible at most sixteen times.
// - Protection in force when both access bit and temp unprotect are zero and disable and re-enable registers match.
// - Temp unprotect bit is written only when fetching from internal flash.
`timescale 1ns/1ns
`include "fwos_defs.svh"
module fwos_seq
   import fwos_pkg::*;
(
   input wire logic core_clk_i,
   input wire logic rst_n_i,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic fetch_from_flash_i,
   input wire logic indirect_access_i,
   output logic array_wr_o,
   output logic [1:0] array_kind_o,
   output logic [23:0] array_addr_o,
   output logic [63:0] array_wdata_o,
   output logic access_protected_o
);
   // ------------------------------------------------------------
   // Bus write channel
   // ------------------------------------------------------------
   logic aw_held_q, w_held_q, bvalid_q, awready_q, wready_q;
   logic [7:0] awaddr_q;
   logic [31:0] wdata_q;
   logic [3:0] wstrb_q;
   logic [1:0] bresp_q;
   wire aw_take = s_axi_awvalid & awready_q;
   wire w_take = s_axi_wvalid & wready_q;
   wire wr_fire = aw_held_q & w_held_q & ~bvalid_q;
   wire [15:0] wr_val = wdata_q[15:0];
   // Only a full 16-bit low lane counts as a legal write
   wire wr_width_ok = (wstrb_q == 4'h3);
   logic prot_q;
   wire is_temp_reg = (awaddr_q == `FWOS_OFF_TEMP_UNPROT);
   wire is_nv_reg = (awaddr_q >= `FWOS_OFF_NV_WP);
   wire wr_mapped = (awaddr_q <= `FWOS_OFF_NV_REEN) & (awaddr_q[1:0] == 2'h0);
   wire wr_ok = wr_mapped & wr_width_ok & indirect_access_i & ~is_nv_reg & (~prot_q | is_temp_reg);
   wire wr_en = wr_fire & wr_ok;
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         aw_held_q <= 1'b0;
         w_held_q <= 1'b0;
         bvalid_q <= 1'b0;
         awready_q <= 1'b0;
         wready_q <= 1'b0;
         awaddr_q <= 8'h00;
         wdata_q <= 32'h00000000;
         wstrb_q <= 4'h0;
         bresp_q <= 2'h0;
      end else begin
         awready_q <= ~aw_held_q & ~aw_take;
         wready_q <= ~w_held_q & ~w_take;
         if (aw_take) begin
            aw_held_q <= 1'b1;
            awaddr_q <= s_axi_awaddr;
         end
         if (w_take) begin
            w_held_q <= 1'b1;
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
         end
         if (wr_fire) begin
            bvalid_q <= 1'b1;
            bresp_q <= wr_ok ? 2'h0 : 2'h2;
         end else if (bvalid_q & s_axi_bready) begin
            bvalid_q <= 1'b0;
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
         end
      end
   end
   assign s_axi_awready = awready_q;
   assign s_axi_wready = wready_q;
   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp = bresp_q;

   // ------------------------------------------------------------
   // Register file
   // ------------------------------------------------------------
   logic [15:0] ctrl0_low_q, ctrl0_high_q, sector_select_low_q, sector_select_high_q;
   logic [15:0] target_addr_low_q, target_addr_high_q;
   logic [15:0] wdata0_low_q, wdata0_high_q, wdata1_low_q, wdata1_high_q;
   logic [15:0] error_reg_q, nv_write_protect_reg_q, nv_access_protect_reg0_q;
   logic [15:0] nv_disable_reg_q, nv_reenable_reg_q;
   logic temp_unprotect_bit_q;
   fwos_state_e state_q;
   logic [10:0] cnt_q;
   logic [15:0] suspend_bit_sel_q;
   wire w_c0h = wr_en & (awaddr_q == `FWOS_OFF_CTRL0_HIGH);
   wire running = (state_q == FWOS_PROG) | (state_q == FWOS_ERASE) | (state_q == FWOS_PROG_IN_SUSPEND_BIT);
   wire start_req = w_c0h & wr_val[`FWOS_BIT_START] & ~running;
   wire [15:0] sel_now = wr_val & `FWOS_SEL_MASK;
   wire one_sel = $onehot(sel_now);
   wire op_done = running & (cnt_q == 11'h000);
   // suspend only for plain program or erase
   wire suspend_bit_req = w_c0h & wr_val[`FWOS_BIT_SUSPEND_BIT] & ((state_q == FWOS_PROG) | (state_q == FWOS_ERASE));
   wire resume_bad = start_req & (state_q == FWOS_SUSPENDED) & (sel_now != suspend_bit_sel_q) &
                     ~(sel_now[`FWOS_BIT_WPG] | sel_now[`FWOS_BIT_DWORD_PROG_SEL]);
   wire is_nv_target = (target_addr_high_q == `FWOS_NV_ADDR_HIGH);
   // disable and re-enable allowed while an enable bit is left; sixteen at most
   wire reenable_ok = (nv_reenable_reg_q != 16'h0000);
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ctrl0_low_q <= `FWOS_RST_ZERO;
         ctrl0_high_q <= `FWOS_RST_ZERO;
         sector_select_low_q <= `FWOS_RST_ZERO;
         sector_select_high_q <= `FWOS_RST_ZERO;
         target_addr_low_q <= `FWOS_RST_ZERO;
         target_addr_high_q <= `FWOS_RST_ZERO;
         wdata0_low_q <= `FWOS_RST_ZERO;
         wdata0_high_q <= `FWOS_RST_ZERO;
         wdata1_low_q <= `FWOS_RST_ZERO;
         wdata1_high_q <= `FWOS_RST_ZERO;
         error_reg_q <= `FWOS_RST_ZERO;
         temp_unprotect_bit_q <= 1'b0;
      end else begin
         if (wr_en) begin
            unique case (awaddr_q)
               `FWOS_OFF_CTRL0_LOW: ctrl0_low_q <= wr_val;
               // clearing select bits before start simply cancels
               `FWOS_OFF_CTRL0_HIGH: if (!running) ctrl0_high_q <= wr_val;
               `FWOS_OFF_SEC_LOW: sector_select_low_q <= wr_val;
               `FWOS_OFF_SEC_HIGH: sector_select_high_q <= wr_val;
               `FWOS_OFF_ADDR_LOW: target_addr_low_q <= wr_val;
               `FWOS_OFF_ADDR_HIGH: target_addr_high_q <= wr_val;
               `FWOS_OFF_WD0_LOW: wdata0_low_q <= wr_val;
               `FWOS_OFF_WD0_HIGH: wdata0_high_q <= wr_val;
               `FWOS_OFF_WD1_LOW: wdata1_low_q <= wr_val;
               `FWOS_OFF_WD1_HIGH: wdata1_high_q <= wr_val;
               `FWOS_OFF_ERROR: error_reg_q <= wr_val;
               // temp unprotect only from flash fetch
               `FWOS_OFF_TEMP_UNPROT: if (fetch_from_flash_i) temp_unprotect_bit_q <= wr_val[0];
               default: ;
            endcase
         end
         // abort sets resume error, set wins over a clear
         if (resume_bad)
            error_reg_q[`FWOS_BIT_RESERR] <= 1'b1;
         if (suspend_bit_req)
            ctrl0_high_q <= (ctrl0_high_q & ~16'h8010) | 16'h4000;
         // start and busy fall at completion
         if (op_done)
            ctrl0_high_q <= 16'h0000;
         // finished erase shows empty sector select
         if (op_done & (state_q == FWOS_ERASE)) begin
            sector_select_low_q <= 16'h0000;
            sector_select_high_q <= 16'h0000;
         end
         if (start_req) begin
            if (one_sel & ~resume_bad & ~ctrl0_high_q[`FWOS_BIT_SUSPEND_BIT])
               ctrl0_high_q <= sel_now | 16'h8010;
            else
               ctrl0_high_q <= 16'h0000;
         end
      end
   end

   // ------------------------------------------------------------
   // Operation sequencer
   // ------------------------------------------------------------
   logic arr_wr_q;
   logic [1:0] arr_kind_q;
   logic [23:0] arr_addr_q;
   logic [63:0] arr_wdata_q;
   fwos_state_e state_d;
   wire go = start_req & one_sel & ~resume_bad & ~ctrl0_high_q[`FWOS_BIT_SUSPEND_BIT];
   always_comb begin
      state_d = state_q;
      unique case (state_q)
         FWOS_IDLE:
            if (go & sel_now[`FWOS_BIT_SER])
               state_d = FWOS_ERASE;
            else if (go)
               state_d = FWOS_PROG;
         FWOS_PROG:
            if (suspend_bit_req)
               state_d = FWOS_SUSPENDED;
            else if (op_done)
               state_d = FWOS_IDLE;
         FWOS_ERASE:
            if (suspend_bit_req)
               state_d = FWOS_SUSPENDED;
            else if (op_done)
               state_d = FWOS_IDLE;
         FWOS_PROG_IN_SUSPEND_BIT:
            if (op_done)
               state_d = FWOS_SUSPENDED;
         FWOS_SUSPENDED:
            if (resume_bad)
               state_d = FWOS_IDLE;
            else if (go & (suspend_bit_sel_q[`FWOS_BIT_SER]) & (sel_now[`FWOS_BIT_WPG] | sel_now[`FWOS_BIT_DWORD_PROG_SEL]))
               state_d = FWOS_PROG_IN_SUSPEND_BIT;
            // erase resumes on erase select and start
            else if (go & sel_now[`FWOS_BIT_SER])
               state_d = FWOS_ERASE;
            else if (go)
               state_d = FWOS_PROG;
      endcase
   end
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_q <= FWOS_IDLE;
         cnt_q <= 11'h000;
         suspend_bit_sel_q <= 16'h0000;
      end else begin
         state_q <= state_d;
         if (suspend_bit_req)
            suspend_bit_sel_q <= ctrl0_high_q & `FWOS_SEL_MASK;
         if (go & (state_q != FWOS_SUSPENDED | ~suspend_bit_sel_q[`FWOS_BIT_SER] | sel_now[`FWOS_BIT_SER]))
            cnt_q <= sel_now[`FWOS_BIT_SER] ? 11'(`FWOS_ERASE_CYC - 1) : 11'(`FWOS_PROG_CYC - 1);
         else if (go)
            cnt_q <= 11'(`FWOS_PROG_CYC - 1);
         else if (running & (cnt_q != 11'h000))
            cnt_q <= cnt_q - 11'h001;
      end
   end

   // ------------------------------------------------------------
   // Array command and protection store
   // ------------------------------------------------------------
   wire commit = op_done;
   wire [15:0] sel_run = ctrl0_high_q & `FWOS_SEL_MASK;
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         arr_wr_q <= 1'b0;
         arr_kind_q <= 2'h0;
         arr_addr_q <= 24'h000000;
         arr_wdata_q <= 64'h0;
         nv_write_protect_reg_q <= `FWOS_RST_NV;
         nv_access_protect_reg0_q <= `FWOS_RST_NV;
         nv_disable_reg_q <= `FWOS_RST_NV;
         nv_reenable_reg_q <= `FWOS_RST_NV;
         prot_q <= 1'b0;
      end else begin
         arr_wr_q <= 1'b0;
         // protected when the access bit is zero, unless permanently disabled or temporarily lifted
         prot_q <= ~nv_access_protect_reg0_q[`FWOS_BIT_ACCESS_PROTECT_BIT] & ~temp_unprotect_bit_q &
                   (nv_disable_reg_q == nv_reenable_reg_q);
         if (commit & ~sel_run[`FWOS_BIT_SPR]) begin
            arr_wr_q <= 1'b1;
            if (sel_run[`FWOS_BIT_SER]) begin
               arr_kind_q <= 2'h2;
               arr_addr_q <= 24'h000000;
               arr_wdata_q <= {32'h0, sector_select_high_q, sector_select_low_q};
            end else if (sel_run[`FWOS_BIT_DWORD_PROG_SEL]) begin
               arr_kind_q <= 2'h1;
               arr_addr_q <= {target_addr_high_q[7:0], target_addr_low_q[15:3], 3'h0};
               arr_wdata_q <= {wdata1_high_q, wdata1_low_q, wdata0_high_q, wdata0_low_q};
            end else begin
               arr_kind_q <= 2'h0;
               arr_addr_q <= {target_addr_high_q[7:0], target_addr_low_q};
               arr_wdata_q <= {32'h0, wdata0_high_q, wdata0_low_q};
            end
         end
         if (commit & sel_run[`FWOS_BIT_SPR] & is_nv_target) begin
            if (target_addr_low_q == `FWOS_NV_WP_LOW)
               nv_write_protect_reg_q <= nv_write_protect_reg_q & wdata0_low_q;
            if (target_addr_low_q == `FWOS_NV_AP0_LOW)
               nv_access_protect_reg0_q <= nv_access_protect_reg0_q & wdata0_low_q;
            // sixteen disable and enable bits bound the cycles
            if (target_addr_low_q == `FWOS_NV_AP1_LOW & temp_unprotect_bit_q & reenable_ok) begin
               nv_disable_reg_q <= nv_disable_reg_q & wdata0_low_q;
               nv_reenable_reg_q <= nv_reenable_reg_q & (wdata0_high_q | nv_disable_reg_q);
            end
         end
      end
   end
   assign array_wr_o = arr_wr_q;
   assign array_kind_o = arr_kind_q;
   assign array_addr_o = arr_addr_q;
   assign array_wdata_o = arr_wdata_q;
   assign access_protected_o = prot_q;

   // ------------------------------------------------------------
   // Bus read channel
   // ------------------------------------------------------------
   logic rvalid_q, arready_q;
   logic [31:0] rdata_q;
   logic [1:0] rresp_q;
   // erase and suspend read low during program in erase suspend
   wire [15:0] c0h_view = (state_q == FWOS_PROG_IN_SUSPEND_BIT) ? (ctrl0_high_q & 16'hB7FF) : ctrl0_high_q;
   wire ar_take = s_axi_arvalid & arready_q;
   logic [15:0] rd_val;
   logic rd_hit;
   always_comb begin
      rd_hit = 1'b1;
      unique case (s_axi_araddr)
         `FWOS_OFF_CTRL0_LOW: rd_val = ctrl0_low_q;
         `FWOS_OFF_CTRL0_HIGH: rd_val = c0h_view;
         `FWOS_OFF_SEC_LOW: rd_val = sector_select_low_q;
         `FWOS_OFF_SEC_HIGH: rd_val = sector_select_high_q;
         `FWOS_OFF_ADDR_LOW: rd_val = target_addr_low_q;
         `FWOS_OFF_ADDR_HIGH: rd_val = target_addr_high_q;
         `FWOS_OFF_WD0_LOW: rd_val = wdata0_low_q;
         `FWOS_OFF_WD0_HIGH: rd_val = wdata0_high_q;
         `FWOS_OFF_WD1_LOW: rd_val = wdata1_low_q;
         `FWOS_OFF_WD1_HIGH: rd_val = wdata1_high_q;
         `FWOS_OFF_ERROR: rd_val = error_reg_q;
         `FWOS_OFF_TEMP_UNPROT: rd_val = {15'h0000, temp_unprotect_bit_q};
         `FWOS_OFF_NV_WP: rd_val = nv_write_protect_reg_q;
         `FWOS_OFF_NV_AP0: rd_val = nv_access_protect_reg0_q;
         `FWOS_OFF_NV_DIS: rd_val = nv_disable_reg_q;
         `FWOS_OFF_NV_REEN: rd_val = nv_reenable_reg_q;
         default: begin
            rd_val = 16'h0000;
            rd_hit = 1'b0;
         end
      endcase
   end
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rvalid_q <= 1'b0;
         arready_q <= 1'b0;
         rdata_q <= 32'h00000000;
         rresp_q <= 2'h0;
      end else begin
         arready_q <= ~rvalid_q & ~ar_take;
         if (ar_take) begin
            rvalid_q <= 1'b1;
            rdata_q <= {16'h0000, rd_val};
            rresp_q <= rd_hit ? 2'h0 : 2'h2;
         end else if (rvalid_q & s_axi_rready) begin
            rvalid_q <= 1'b0;
         end
      end
   end
   assign s_axi_arready = arready_q;
   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rdata = rdata_q;
   assign s_axi_rresp = rresp_q;

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   a_start_busy: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      go |=> ctrl0_high_q[`FWOS_BIT_BUSY] & ctrl0_high_q[`FWOS_BIT_START])
      else $error("busy not set after start");
   a_done_clear: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      op_done & ~start_req |=> ~ctrl0_high_q[`FWOS_BIT_BUSY])
      else $error("busy stuck after completion");
   a_suspend_bit_state: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      suspend_bit_req |=> state_q == FWOS_SUSPENDED)
      else $error("suspend not taken");
   a_no_suspend_bit_prog: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      state_q == FWOS_PROG_IN_SUSPEND_BIT |-> c0h_view[`FWOS_BIT_SER] == 1'b0 && c0h_view[`FWOS_BIT_SUSPEND_BIT] == 1'b0)
      else $error("erase bits visible during suspend program");
   a_resume_err: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      resume_bad |=> error_reg_q[`FWOS_BIT_RESERR] && state_q == FWOS_IDLE)
      else $error("bad resume not flagged");
   a_erase_clears: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      op_done && state_q == FWOS_ERASE |=> sector_select_low_q == 16'h0000 && sector_select_high_q == 16'h0000)
      else $error("sector select not cleared");
   a_width_only: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      wr_fire && wstrb_q != 4'h3 |=> s_axi_bresp == 2'h2)
      else $error("wrong width accepted");
   a_dword_align: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      array_wr_o && array_kind_o == 2'h1 |-> array_addr_o[`FWOS_BIT_ADDR2] == 1'b0)
      else $error("double word not aligned");
   a_cancel_quiet: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      state_q == FWOS_IDLE && !running |=> !array_wr_o)
      else $error("array written without operation");
endmodule

// File: fwos_array_model.sv
// Flash array model that records each commit of the sequencer
`timescale 1ns/1ns
module fwos_array_model (
   input wire logic core_clk_i,
   input wire logic array_wr_i,
   input wire logic [1:0] kind_i,
   input wire logic [23:0] addr_i,
   input wire logic [63:0] wdata_i,
   output int n_commits_o,
   output logic [89:0] last_o
);
   initial n_commits_o = 0;
   // Capture kind, address and data of every commit pulse
   always @(posedge core_clk_i) begin
      if (array_wr_i === 1'h1) begin
         n_commits_o <= n_commits_o + 1;
         last_o <= {kind_i, addr_i, wdata_i};
      end
   end
endmodule

// File: tb.sv
// Self-checking bench of the flash sequencer over AXI4-Lite
`timescale 1ns/1ns
module tb;
   import fwos_pkg::*;
   logic core_clk_i = 1'h0, rst_n_i = 1'h0, fetch_from_flash_i = 1'h0, indirect_access_i = 1'h1;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rdat;
   logic [3:0] s_axi_wstrb = 4'h3;
   logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, array_wr_o, access_protected_o;
   logic [1:0] s_axi_bresp, s_axi_rresp, array_kind_o, resp;
   logic [23:0] array_addr_o;
   logic [63:0] array_wdata_o;
   logic [89:0] last;
   int n_errors = 0, n_compared = 0, n_commits, cyc = 0, base;
   fwos_seq i_dut (.core_clk_i, .rst_n_i, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
      .fetch_from_flash_i, .indirect_access_i, .array_wr_o, .array_kind_o, .array_addr_o, .array_wdata_o,
      .access_protected_o);
   fwos_array_model i_array (.core_clk_i, .array_wr_i(array_wr_o), .kind_i(array_kind_o),
      .addr_i(array_addr_o), .wdata_i(array_wdata_o), .n_commits_o(n_commits), .last_o(last));
   always #20 core_clk_i = ~core_clk_i;
   always @(posedge core_clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_errors = n_errors + 1;
         print_verdict;
      end
   end
   // ------------------------------
   // Bus tasks and comparison
   // ------------------------------
   task print_verdict;
      if (n_errors == 0 && n_compared > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   task chk(input logic [89:0] e, input logic [89:0] g, input string nm);
      n_compared++;
      if (g !== e) begin
         n_errors++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask
   task wr(input logic [7:0] a, input logic [15:0] d, input logic [3:0] s = 4'h3);
      @(posedge core_clk_i);
      s_axi_awaddr <= a;
      s_axi_wdata <= {16'h0000, d};
      s_axi_wstrb <= s;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      do begin
         @(posedge core_clk_i);
         if (s_axi_awready && s_axi_awvalid) s_axi_awvalid <= 1'h0;
         if (s_axi_wready && s_axi_wvalid) s_axi_wvalid <= 1'h0;
      end while (s_axi_bvalid !== 1'h1);
      resp = s_axi_bresp;
      s_axi_bready <= 1'h0;
   endtask
   task rd(input logic [7:0] a);
      @(posedge core_clk_i);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      do begin
         @(posedge core_clk_i);
         if (s_axi_arready && s_axi_arvalid) s_axi_arvalid <= 1'h0;
      end while (s_axi_rvalid !== 1'h1);
      rdat = s_axi_rdata;
      resp = s_axi_rresp;
      s_axi_rready <= 1'h0;
   endtask
   // Select, load sector mask, address and data, then start
   task op(input logic [15:0] sel, input logic [31:0] ad, input logic [63:0] wd, input logic [31:0] sec);
      logic [15:0] v [9];
      v = '{sel, sec[15:0], sec[31:16], ad[15:0], ad[31:16], wd[15:0], wd[31:16], wd[47:32], wd[63:48]};
      for (int k = 0; k < 9; k++) wr(8'(4 + 4 * k), v[k]);
      wr(8'h04, sel | 16'h8000);
   endtask
   task tau(input logic [15:0] b);
      fetch_from_flash_i <= 1'h1;
      wr(8'h2C, b);
      fetch_from_flash_i <= 1'h0;
   endtask
   task wait_idle;
      rd(8'h04);
      for (int i = 0; i < 400 && rdat[4] !== 1'h0; i++) rd(8'h04);
   endtask
   // ------------------------------
   // Test sequence
   // ------------------------------
   initial begin
      repeat (8) @(posedge core_clk_i);
      rst_n_i <= 1'h1;
      @(posedge core_clk_i);
      base = n_commits;
      op(16'h2000, 32'h00025554, 64'h000000005555AAAA, 32'h0);
      rd(8'h04);
      chk(90'h1, 90'(rdat[4]), "busy");
      wait_idle;
      chk(90'h0, 90'(rdat), "ctrl0_high");
      chk({2'h0, 24'h025554, 64'h000000005555AAAA}, last, "word");
      op(16'h1000, 32'h0003555C, 64'hAA55AA5555AA55AA, 32'h0);
      wait_idle;
      chk({2'h1, 24'h035558, 64'hAA55AA5555AA55AA}, last, "dword");
      op(16'h0800, 32'h0, 64'h0, 32'h00000003);
      wait_idle;
      chk({2'h2, 24'h0, 64'h3}, last, "erase");
      rd(8'h08);
      chk(90'h0, 90'(rdat), "sector_select_low");
      rd(8'h0C);
      chk(90'h0, 90'(rdat), "sector_select_high");
      wr(8'h04, 16'h2000);
      wr(8'h04, 16'h0000);
      repeat (60) @(posedge core_clk_i);
      chk(90'(base + 3), 90'(n_commits), "commits");
      wr(8'h10, 16'h1234, 4'hF);
      chk(90'h2, 90'(resp), "strobe resp");
      indirect_access_i <= 1'h0;
      wr(8'h10, 16'h1234);
      chk(90'h2, 90'(resp), "direct resp");
      indirect_access_i <= 1'h1;
      rd(8'h10);
      chk(90'h0, 90'(rdat), "target_addr_low");
      rd(8'h40);
      chk(90'h2, 90'(resp), "unmapped resp");
      op(16'h0100, 32'h0008DFB4, 64'h00000000FFFFFFF0, 32'h0);
      wait_idle;
      rd(8'h30);
      chk(90'hFFF0, 90'(rdat), "nv_write_protect_reg");
      chk(90'(base + 3), 90'(n_commits), "commits");
      for (int f = 0; f < 2; f++) begin
         fetch_from_flash_i <= 1'(f);
         wr(8'h2C, 16'h0001);
         rd(8'h2C);
         chk(90'(f), 90'(rdat), "temp_unprotect_reg");
      end
      wr(8'h2C, 16'h0000);
      fetch_from_flash_i <= 1'h0;
      op(16'h0800, 32'h0, 64'h0, 32'h00000001);
      repeat (20) @(posedge core_clk_i);
      wr(8'h04, 16'h4800);
      rd(8'h04);
      chk(90'h0, 90'({rdat[15], rdat[4]}), "suspended");
      wr(8'h04, 16'h0000);
      op(16'h2000, 32'h00045554, 64'h000000005555AAAA, 32'h1);
      wr(8'h04, 16'h4000);
      rd(8'h04);
      chk(90'h0, 90'({rdat[14], rdat[11]}), "erase and suspend bits");
      wait_idle;
      chk({2'h0, 24'h045554, 64'h000000005555AAAA}, last, "program in suspend");
      wr(8'h04, 16'h0800);
      wr(8'h04, 16'h8800);
      wait_idle;
      chk({2'h2, 24'h0, 64'h1}, last, "resumed erase");
      op(16'h0800, 32'h0, 64'h0, 32'h00000001);
      repeat (20) @(posedge core_clk_i);
      wr(8'h04, 16'h4800);
      wr(8'h04, 16'h0000);
      wr(8'h04, 16'h8100);
      rd(8'h28);
      chk(90'h1, 90'(rdat[0]), "resume_error_flag");
      op(16'h0100, 32'h0008DFB8, 64'h00000000FFFFFFFC, 32'h1);
      wait_idle;
      chk(90'h1, 90'(access_protected_o), "access_protected");
      wr(8'h10, 16'h0055);
      chk(90'h2, 90'(resp), "protected resp");
      tau(16'h0001);
      op(16'h0100, 32'h0008DFBC, 64'h00000000FFFFFFFE, 32'h1);
      wait_idle;
      tau(16'h0000);
      repeat (2) @(posedge core_clk_i);
      chk(90'h0, 90'(access_protected_o), "access_protected");
      tau(16'h0001);
      op(16'h0100, 32'h0008DFBC, 64'h00000000FFFEFFFF, 32'h1);
      wait_idle;
      rd(8'h3C);
      chk(90'hFFFE, 90'(rdat), "nv_reenable_reg");
      tau(16'h0000);
      repeat (2) @(posedge core_clk_i);
      chk(90'h1, 90'(access_protected_o), "access_protected");
      print_verdict;
   end
endmodule
